//--- design/scu_uart.sv
// smart-card uart status flags, etu configuration and character engine
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - new character while receive holding register full sets overrun flag.
// - io not released at 10.25 etu after start sets framing flag; status read clears.
// - status bit 0 means transmit empty in transmit mode, receive full in receive mode.
// - empty flag set when next character may be written; cleared by write or mode exit.
// - full flag set when receive buffer full; cleared when software reads it.
// - etu counted by 8-bit down-counter from divider value to one, auto reload.
// - wake enable plus falling external interrupt pin wakes from power-down only.
// - character interrupt mask blocks char interrupt; mixed status copy is polled.
// - wake enable plus falling host receive pin wakes from power-down only.
// - sync card mode bypasses engine; bit 0 of holding registers meets io line.
// - auto convention bit 1 uses software bit; 0 detects from first session char.
// - half-unit bit halves etu, unless card clock equals crystal clock.
// - prescaler 32 when select is 1, else 31; etu is prescaler times divider.
// - interrupt low while error flag set; flag clears 2 us after status read.
// - interrupt also low when char flag set and char mask clear.
// - char flag clears three cycles after holding access, and on transmit-to-receive.
module scu_uart (
    input  wire logic       CLOCK,
    input  wire logic       RST,
    input  wire logic [3:0] ADDR,
    input  wire logic [7:0] WDATA,
    input  wire logic       WR,
    input  wire logic       RD,
    output logic [7:0]      RDATA,
    input  wire logic       IO_IN,
    output logic            IO_OUT,
    output logic            IO_OE,
    input  wire logic       EXT_IRQ_PIN_N,
    input  wire logic       HOST_RX,
    input  wire logic       POWER_DOWN,
    input  wire logic       CARD_CLK_IS_XTAL,
    output logic            IRQ_OUT_N,
    output logic            WAKE,
    output logic            SYNC_CLK
);

    scu_pkg::scu_bus_s   bus;
    scu_pkg::scu_cfg1_s  cfg1;
    scu_pkg::scu_cfg2_s  cfg2;
    scu_pkg::scu_state_e state;

    logic [4:0]  pins_raw;
    logic [4:0]  sync1;
    logic [4:0]  sync2;
    logic [4:0]  sync3;
    logic        io_s;
    logic        io_fall;
    logic        ext_fall;
    logic        rx_pin_fall;
    logic        power_down_s;
    logic        clk_is_xtal_s;

    logic [7:0]  divider;
    logic        sync_clock_bit;
    logic [7:0]  tx_hold;
    logic [7:0]  rx_hold;
    logic        tx_pending;
    logic        rx_full;
    logic        overrun_flag;
    logic        framing_error_flag;
    logic        tx_empty_rx_full_flag;
    logic [scu_pkg::EV_W-1:0] events;
    logic [scu_pkg::EV_W-1:0] evt_mask;
    logic [scu_pkg::EV_W-1:0] evt_set;

    logic        etu_restart;
    logic        etu_tick;
    logic [12:0] etu_phase;
    logic [12:0] etu_period;
    logic [3:0]  etu_count;
    logic [7:0]  rx_raw;
    logic [9:0]  tx_shift;
    logic        convention_bit_detected;
    logic        convention_bit_done;
    logic        inverse;
    logic [7:0]  rx_decoded;
    logic [7:0]  tx_encoded;
    logic        tx_parity;

    logic        set_ovr;
    logic        set_fer;
    logic        set_char;
    logic        char_store;
    logic        tx_load;
    logic        tx_mode_q;
    logic        wake_event;
    logic [2:0]  char_clr_pipe;
    logic [4:0]  status_clr_cnt;
    logic [1:0]  status_clr_sel;
    logic        hold_wr;
    logic        hold_rd;
    logic        status_rd;

    assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
    assign hold_wr   = bus.wr && (bus.addr == scu_pkg::OFF_HOLD);
    assign hold_rd   = bus.rd && (bus.addr == scu_pkg::OFF_HOLD);
    assign status_rd = bus.rd && (bus.addr == scu_pkg::OFF_STATUS);

    // all pins cross into the clock domain through two flops before use
    assign pins_raw = {IO_IN, EXT_IRQ_PIN_N, HOST_RX, POWER_DOWN, CARD_CLK_IS_XTAL};
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_sync
            always_ff @(posedge CLOCK or posedge RST) begin
                if (RST) begin
                    sync1[gi] <= scu_pkg::SYNC_RESET[gi];
                    sync2[gi] <= scu_pkg::SYNC_RESET[gi];
                    sync3[gi] <= scu_pkg::SYNC_RESET[gi];
                end else begin
                    sync1[gi] <= pins_raw[gi];
                    sync2[gi] <= sync1[gi];
                    sync3[gi] <= sync2[gi];
                end
            end
        end
    endgenerate

    assign io_s          = sync2[4];
    assign io_fall       = sync3[4] && !sync2[4];
    assign ext_fall      = sync3[3] && !sync2[3];
    assign rx_pin_fall   = sync3[2] && !sync2[2];
    assign power_down_s  = sync2[1];
    assign clk_is_xtal_s = sync2[0];

    scu_etu_timer u_etu (
        .clk              (CLOCK),
        .rst              (RST),
        .restart          (etu_restart),
        .divider          (divider),
        .prescaler_select (cfg2.prescaler_select),
        .half_unit        (cfg2.half_unit_bit && !clk_is_xtal_s),
        .tick             (etu_tick),
        .phase            (etu_phase),
        .period           (etu_period)
    );

    // convention: software bit, or the one learnt from the first session character
    assign inverse = cfg2.auto_convention_n ? cfg1.convention_bit : convention_bit_detected;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            rx_decoded[i] = inverse ? !rx_raw[7-i] : rx_raw[i];
            tx_encoded[i] = inverse ? !tx_hold[7-i] : tx_hold[i];
        end
    end
    assign tx_parity = inverse ? !(^tx_hold) : (^tx_hold);

    // software-written registers
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            divider        <= scu_pkg::DIVIDER_RESET;
            cfg1           <= scu_pkg::CONFIG_RESET;
            cfg2           <= scu_pkg::CONFIG_RESET;
            sync_clock_bit <= 1'b0;
            evt_mask       <= scu_pkg::EVENTS_RESET;
        end else if (bus.wr) begin
            unique case (bus.addr)
                scu_pkg::OFF_DIVIDER:    divider        <= bus.wdata;
                scu_pkg::OFF_CONFIG_TWO: cfg2           <= bus.wdata;
                scu_pkg::OFF_CONFIG_ONE: cfg1           <= bus.wdata;
                scu_pkg::OFF_CARD_CLOCK: sync_clock_bit <= bus.wdata[0];
                scu_pkg::OFF_EVT_MASK:   evt_mask       <= bus.wdata[scu_pkg::EV_W-1:0];
                default: ;
            endcase
        end
    end

    // character engine
    assign etu_restart = (state == scu_pkg::ST_IDLE) && !cfg2.sync_card_mode
                         && ((!cfg1.tx_mode && io_fall) || (cfg1.tx_mode && tx_pending));
    assign tx_load     = (state == scu_pkg::ST_IDLE) && !cfg2.sync_card_mode
                         && cfg1.tx_mode && tx_pending;
    assign char_store  = (state == scu_pkg::ST_RX) && (etu_count == scu_pkg::FRAME_ETU)
                         && (etu_phase == (etu_period >> 2));

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            state     <= scu_pkg::ST_IDLE;
            etu_count <= 4'h0;
            rx_raw    <= 8'h00;
            tx_shift  <= 10'h3FF;
        end else begin
            unique case (state)
                scu_pkg::ST_IDLE: begin
                    etu_count <= 4'h0;
                    if (cfg2.sync_card_mode) begin
                        state <= scu_pkg::ST_SYNC;
                    end else if (tx_load) begin
                        tx_shift <= {tx_parity, tx_encoded, 1'b0};
                        state    <= scu_pkg::ST_TX;
                    end else if (etu_restart) begin
                        state <= scu_pkg::ST_RX;
                    end
                end
                scu_pkg::ST_RX: begin
                    if (etu_tick) begin
                        etu_count <= 4'(etu_count + 4'h1);
                    end
                    if (etu_phase == (etu_period >> 1) && etu_count >= 4'h1
                        && etu_count <= 4'h8) begin
                        rx_raw <= {io_s, rx_raw[7:1]};
                    end
                    if (char_store || cfg1.tx_mode) begin
                        state <= scu_pkg::ST_IDLE;
                    end
                end
                scu_pkg::ST_TX: begin
                    // frame of start, eight data, parity, then two etu released
                    if (etu_tick) begin
                        etu_count <= 4'(etu_count + 4'h1);
                        tx_shift  <= {1'b1, tx_shift[9:1]};
                    end
                    if (etu_tick && etu_count == 4'(scu_pkg::TX_END_ETU - 4'h1)) begin
                        state <= scu_pkg::ST_IDLE;
                    end
                end
                scu_pkg::ST_SYNC: begin
                    if (!cfg2.sync_card_mode) begin
                        state <= scu_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // io line: open drain, only ever pulled low
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            IO_OUT   <= 1'b0;
            IO_OE    <= 1'b0;
            SYNC_CLK <= 1'b0;
        end else begin
            IO_OUT   <= 1'b0;
            SYNC_CLK <= (state == scu_pkg::ST_SYNC) && sync_clock_bit;
            if (state == scu_pkg::ST_SYNC) begin
                IO_OE <= cfg1.tx_mode && !tx_hold[0];
            end else begin
                IO_OE <= (state == scu_pkg::ST_TX) && !tx_shift[0];
            end
        end
    end

    // holding registers
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            tx_hold    <= 8'h00;
            tx_pending <= 1'b0;
            rx_hold    <= 8'h00;
            rx_full    <= 1'b0;
        end else begin
            if (hold_wr) begin
                tx_hold <= bus.wdata;
            end
            if (hold_wr && cfg1.tx_mode && !cfg2.sync_card_mode) begin
                tx_pending <= 1'b1;
            end else if (tx_load || !cfg1.tx_mode) begin
                tx_pending <= 1'b0;
            end
            if (state == scu_pkg::ST_SYNC && !cfg1.tx_mode) begin
                rx_hold <= {rx_hold[7:1], io_s};
            end else if (char_store) begin
                rx_hold <= rx_decoded;
            end
            if (char_store) begin
                rx_full <= 1'b1;
            end else if (hold_rd) begin
                rx_full <= 1'b0;
            end
        end
    end

    // convention detection restarts whenever the session bit drops
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            convention_bit_detected <= 1'b0;
            convention_bit_done     <= 1'b0;
        end else if (!cfg1.start_session) begin
            convention_bit_done <= 1'b0;
        end else if (char_store && !convention_bit_done && !cfg2.auto_convention_n) begin
            convention_bit_detected <= (rx_raw == scu_pkg::TS_INVERSE);
            convention_bit_done     <= 1'b1;
        end
    end

    // flag set events
    assign set_ovr    = char_store && rx_full;
    assign set_fer    = char_store && !io_s;
    assign set_char   = char_store || tx_load || (cfg1.tx_mode && !tx_mode_q && !tx_pending);
    assign wake_event = power_down_s && ((cfg2.wake_on_ext_irq_en && ext_fall)
                        || (cfg2.wake_on_host_rx_en && rx_pin_fall));

    // char flag clears three cycles after a holding access
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            char_clr_pipe <= 3'h0;
            tx_mode_q     <= 1'b0;
        end else begin
            char_clr_pipe <= {char_clr_pipe[1:0], hold_wr || hold_rd};
            tx_mode_q     <= cfg1.tx_mode;
        end
    end

    // one bit serves both directions; set wins over any clear
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            tx_empty_rx_full_flag <= 1'b0;
        end else if (set_char) begin
            tx_empty_rx_full_flag <= 1'b1;
        end else if ((char_clr_pipe[scu_pkg::CHAR_CLEAR_CYCLES-1] && (tx_pending || !cfg1.tx_mode))
                     || (tx_mode_q && !cfg1.tx_mode)) begin
            tx_empty_rx_full_flag <= 1'b0;
        end
    end

    // error flags clear a fixed delay after the status read that saw them
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            status_clr_cnt <= 5'h00;
            status_clr_sel <= 2'h0;
        end else if (status_rd) begin
            status_clr_cnt <= 5'(scu_pkg::STATUS_CLEAR_CYCLES);
            status_clr_sel <= {overrun_flag, framing_error_flag};
        end else if (status_clr_cnt != 5'h00) begin
            status_clr_cnt <= 5'(status_clr_cnt - 5'h01);
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            overrun_flag       <= 1'b0;
            framing_error_flag <= 1'b0;
        end else begin
            if (set_ovr) begin
                overrun_flag <= 1'b1;
            end else if (status_clr_cnt == 5'h01 && status_clr_sel[1]) begin
                overrun_flag <= 1'b0;
            end
            if (set_fer) begin
                framing_error_flag <= 1'b1;
            end else if (status_clr_cnt == 5'h01 && status_clr_sel[0]) begin
                framing_error_flag <= 1'b0;
            end
        end
    end

    // sticky event log, write one to clear
    always_comb begin
        evt_set                   = '0;
        evt_set[scu_pkg::EV_CHAR] = set_char;
        evt_set[scu_pkg::EV_FER]  = set_fer;
        evt_set[scu_pkg::EV_OVR]  = set_ovr;
        evt_set[scu_pkg::EV_WAKE] = wake_event;
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            events <= scu_pkg::EVENTS_RESET;
        end else if (bus.wr && bus.addr == scu_pkg::OFF_EVENTS) begin
            events <= (events & ~bus.wdata[scu_pkg::EV_W-1:0]) | evt_set;
        end else begin
            events <= events | evt_set;
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            IRQ_OUT_N <= 1'b1;
            WAKE      <= 1'b0;
        end else begin
            IRQ_OUT_N <= !(overrun_flag || framing_error_flag
                           || (tx_empty_rx_full_flag && !cfg2.char_irq_mask)
                           || (|(events & evt_mask)));
            WAKE      <= wake_event;
        end
    end

    // read data stands in the cycle after the strobe
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            RDATA <= 8'h00;
        end else if (bus.rd) begin
            unique case (bus.addr)
                scu_pkg::OFF_DIVIDER:    RDATA <= divider;
                scu_pkg::OFF_CONFIG_TWO: RDATA <= cfg2;
                scu_pkg::OFF_CONFIG_ONE: RDATA <= cfg1;
                scu_pkg::OFF_CARD_CLOCK: RDATA <= {7'h00, sync_clock_bit};
                scu_pkg::OFF_HOLD:       RDATA <= rx_hold;
                scu_pkg::OFF_STATUS:     RDATA <= {5'h00, overrun_flag, framing_error_flag,
                                                   tx_empty_rx_full_flag};
                scu_pkg::OFF_MIXED:      RDATA <= {5'h00, state == scu_pkg::ST_TX, rx_full,
                                                   tx_empty_rx_full_flag};
                scu_pkg::OFF_EVENTS:     RDATA <= {4'h0, events};
                scu_pkg::OFF_EVT_MASK:   RDATA <= {4'h0, evt_mask};
                default:                 RDATA <= 8'h00;
            endcase
        end else begin
            RDATA <= 8'h00;
        end
    end

endmodule // scu_uart
`default_nettype wire

//--- design/scu_pkg.sv
// shared constants and types for the smart-card uart and etu block
package scu_pkg;

    localparam int ADDR_W = 4;

    // register offsets
    localparam logic [3:0] OFF_CARD_CLOCK = 4'h1;
    localparam logic [3:0] OFF_DIVIDER    = 4'h2;
    localparam logic [3:0] OFF_CONFIG_TWO = 4'h3;
    localparam logic [3:0] OFF_CONFIG_ONE = 4'h6;
    localparam logic [3:0] OFF_MIXED      = 4'h7;
    localparam logic [3:0] OFF_EVENTS     = 4'h8;
    localparam logic [3:0] OFF_EVT_MASK   = 4'h9;
    localparam logic [3:0] OFF_HOLD       = 4'hD;
    localparam logic [3:0] OFF_STATUS     = 4'hE;

    // status bit positions
    localparam int ST_CHAR = 0;
    localparam int ST_FER  = 1;
    localparam int ST_OVR  = 2;

    // event bit positions (events and event mask share this layout)
    localparam int EV_CHAR = 0;
    localparam int EV_FER  = 1;
    localparam int EV_OVR  = 2;
    localparam int EV_WAKE = 3;
    localparam int EV_W    = 4;

    // reset values
    localparam logic [7:0]      DIVIDER_RESET  = 8'h00;
    localparam logic [7:0]      CONFIG_RESET   = 8'h00;
    localparam logic [EV_W-1:0] EVENTS_RESET   = 4'h0;
    localparam logic [4:0]      SYNC_RESET     = 5'h1C;

    // prescaler, counted in half card clocks so the half-unit option stays exact
    localparam logic [5:0] PRESCALE_31   = 6'h1F;
    localparam logic [5:0] PRESCALE_32   = 6'h20;
    localparam logic [6:0] PRE_TARGET_31 = 7'h3E;
    localparam logic [6:0] PRE_TARGET_32 = 7'h40;
    localparam logic [6:0] PRE_STEP_FULL = 7'h02;
    localparam logic [6:0] PRE_STEP_HALF = 7'h04;

    // frame timing in etu
    localparam logic [3:0] FRAME_ETU    = 4'hA;
    localparam logic [3:0] TX_END_ETU   = 4'hC;
    localparam logic [7:0] TS_INVERSE   = 8'h03;

    // time-based counts
    localparam int CLK_PERIOD_NS       = 100;
    localparam int STATUS_CLEAR_NS     = 2000;
    localparam int STATUS_CLEAR_CYCLES = STATUS_CLEAR_NS / CLK_PERIOD_NS;
    localparam int CHAR_CLEAR_CYCLES   = 3;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0]        wdata;
        logic              wr;
        logic              rd;
    } scu_bus_s;

    typedef struct packed {
        logic wake_on_ext_irq_en;
        logic char_irq_mask;
        logic unused;
        logic wake_on_host_rx_en;
        logic sync_card_mode;
        logic auto_convention_n;
        logic half_unit_bit;
        logic prescaler_select;
    } scu_cfg2_s;

    typedef struct packed {
        logic [3:0] unused;
        logic       tx_mode;
        logic       last_char;
        logic       start_session;
        logic       convention_bit;
    } scu_cfg1_s;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_RX   = 4'h2,
        ST_TX   = 4'h4,
        ST_SYNC = 4'h8
    } scu_state_e;

endpackage

//--- design/scu_etu_timer.sv
// etu timing: prescaler plus 8-bit auto-reload down-counter
`timescale 1ns/1ps
`default_nettype none
module scu_etu_timer (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       restart,
    input  wire logic [7:0] divider,
    input  wire logic       prescaler_select,
    input  wire logic       half_unit,
    output logic            tick,
    output logic [12:0]     phase,
    output logic [12:0]     period
);

    logic [6:0]  acc;
    logic [7:0]  down;
    logic [6:0]  step;
    logic [6:0]  target;
    logic [6:0]  sum;
    logic        pre_tick;
    logic [13:0] product;

    // prescaler runs in half clocks: a step of 4 halves the etu exactly
    assign step     = half_unit ? scu_pkg::PRE_STEP_HALF : scu_pkg::PRE_STEP_FULL;
    assign target   = prescaler_select ? scu_pkg::PRE_TARGET_32 : scu_pkg::PRE_TARGET_31;
    assign sum      = acc + step;
    assign pre_tick = (sum >= target);
    assign tick     = pre_tick && (down <= 8'h01) && !restart;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acc <= 7'h00;
        end else if (restart) begin
            acc <= 7'h00;
        end else if (pre_tick) begin
            acc <= 7'(sum - target);
        end else begin
            acc <= sum;
        end
    end

    // counts from the divider value down to one, then reloads
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            down <= 8'h00;
        end else if (restart) begin
            down <= divider;
        end else if (pre_tick) begin
            down <= (down <= 8'h01) ? divider : 8'(down - 8'h01);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase <= 13'h0000;
        end else if (restart || tick) begin
            phase <= 13'h0000;
        end else begin
            phase <= 13'(phase + 13'h0001);
        end
    end

    // a divider of zero gives a zero period; mid-bit sampling then fires at phase 0
    assign product = {8'h00, (prescaler_select ? scu_pkg::PRESCALE_32 : scu_pkg::PRESCALE_31)}
                     * {6'h00, divider};
    assign period  = half_unit ? product[13:1] : product[12:0];

endmodule // scu_etu_timer
`default_nettype wire

//--- dv/scu_card_model.sv
// behavioural smart card on the open-drain io line
`timescale 1ns/1ps
`default_nettype none
module scu_card_model (
    input  wire logic CLOCK,
    input  wire logic IO_OE,
    output logic      IO_IN
);
    logic low = 1'b0;
    // pull-up on the line: low while either side pulls
    assign IO_IN = !(IO_OE || low);
    // start, data lsb first, even parity, stop slot; bad holds it low
    task automatic send(input logic [7:0] d, input logic bad, input int etu);
        logic [10:0] f;
        f = {!bad, ^d, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            low <= !f[i];
            repeat (etu) @(posedge CLOCK);
        end
        low <= 1'b0;
        repeat (etu) @(posedge CLOCK);
    endtask
endmodule // scu_card_model
`default_nettype wire

//--- dv/scu_uart_checker.sv
// port-level assertions for the smart-card uart
`timescale 1ns/1ps
`default_nettype none
module scu_uart_checker (
    input wire logic       CLOCK, RST, RD, IO_OUT, IO_OE, POWER_DOWN,
    input wire logic       IRQ_OUT_N, WAKE, SYNC_CLK,
    input wire logic [3:0] ADDR,
    input wire logic [7:0] RDATA
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RST);
    sequence st_read;
        RD && ADDR == scu_pkg::OFF_STATUS;
    endsequence
    sequence err_seen;
        st_read ##1 RDATA[2:1] != 2'h0;
    endsequence
    AST_RD_IDLE: assert property (!RD |=> RDATA == 8'h00)
        else $error("read data not idle");
    AST_ERR_IRQ: assert property (err_seen |-> !IRQ_OUT_N)
        else $error("error flag without interrupt");
    AST_ST_HIGH: assert property (st_read |=> RDATA[7:3] == 5'h00)
        else $error("status upper bits set");
    AST_RST_LEVELS: assert property ($fell(RST) |-> IRQ_OUT_N && !WAKE && !SYNC_CLK)
        else $error("outputs wrong after reset");
    AST_WAKE_PD: assert property (!POWER_DOWN [*6] |=> !WAKE)
        else $error("wake outside power-down");
    AST_WAKE_PULSE: assert property (WAKE |=> !WAKE)
        else $error("wake longer than one cycle");
    AST_OD_DRIVE: assert property (IO_OE |-> IO_OUT == 1'b0)
        else $error("io driven high");
    AST_UNMAPPED: assert property (RD && ADDR == 4'h0 |=> RDATA == 8'h00)
        else $error("unmapped read not zero");
endmodule // scu_uart_checker
bind scu_uart scu_uart_checker u_scu_uart_checker (.CLOCK(CLOCK), .RST(RST), .RD(RD),
    .IO_OUT(IO_OUT), .IO_OE(IO_OE), .POWER_DOWN(POWER_DOWN), .IRQ_OUT_N(IRQ_OUT_N),
    .WAKE(WAKE), .SYNC_CLK(SYNC_CLK), .ADDR(ADDR), .RDATA(RDATA));
`default_nettype wire

//--- dv/scu_uart_bench.sv
// self-checking bench for the smart-card uart
`timescale 1ns/1ps
`default_nettype none
module scu_uart_bench;
    logic       CLOCK = 0, RST = 1, WR = 0, RD = 0, POWER_DOWN = 0, CARD_CLK_IS_XTAL = 0;
    logic       EXT_IRQ_PIN_N = 1, HOST_RX = 1, s;
    logic [3:0] ADDR = 4'h0;
    logic [7:0] WDATA = 8'h00;
    wire        IO_IN, IO_OUT, IO_OE, IRQ_OUT_N, WAKE, SYNC_CLK;
    wire  [7:0] RDATA;
    int         failures = 0, checks_done = 0;
    initial forever #50 CLOCK = !CLOCK;
    scu_uart u_scu_uart (.CLOCK(CLOCK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
        .RD(RD), .RDATA(RDATA), .IO_IN(IO_IN), .IO_OUT(IO_OUT), .IO_OE(IO_OE),
        .EXT_IRQ_PIN_N(EXT_IRQ_PIN_N), .HOST_RX(HOST_RX), .POWER_DOWN(POWER_DOWN),
        .CARD_CLK_IS_XTAL(CARD_CLK_IS_XTAL), .IRQ_OUT_N(IRQ_OUT_N), .WAKE(WAKE),
        .SYNC_CLK(SYNC_CLK));
    scu_card_model u_scu_card_model (.CLOCK(CLOCK), .IO_OE(IO_OE), .IO_IN(IO_IN));
    task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] e);
        checks_done++;
        if (seen !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, e, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge CLOCK);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        ADDR  <= a;
        WDATA <= d;
        WR    <= 1'b1;
        @(posedge CLOCK);
        WR    <= 1'b0;
        tick(1);
    endtask
    // read data stand only in the next cycle
    task automatic rchk(input string n, input logic [3:0] a, input logic [7:0] e);
        ADDR <= a;
        RD   <= 1'b1;
        @(posedge CLOCK);
        RD   <= 1'b0;
        @(posedge CLOCK);
        chk(n, RDATA, e);
    endtask
    task automatic t_regs;
        rchk("divider", 4'h2, 8'h00);
        rchk("config_two", 4'h3, 8'h00);
        rchk("status", 4'hE, 8'h00);
        wr(4'h2, 8'h01);
        wr(4'h3, 8'h04);
        wr(4'h0, 8'hFF);
        rchk("divider", 4'h2, 8'h01);
        rchk("config_two", 4'h3, 8'h04);
        rchk("unmapped", 4'h0, 8'h00);
    endtask
    task automatic t_rx;
        u_scu_card_model.send(8'h5A, 1'b0, 31);
        rchk("status", 4'hE, 8'h01);
        chk("irq", {7'h00, IRQ_OUT_N}, 8'h00);
        // second character before the first is read
        u_scu_card_model.send(8'hC3, 1'b0, 31);
        rchk("status", 4'hE, 8'h05);
        tick(22);
        rchk("status", 4'hE, 8'h01);
        rchk("hold", 4'hD, 8'hC3);
        tick(3);
        rchk("status", 4'hE, 8'h00);
        chk("irq", {7'h00, IRQ_OUT_N}, 8'h01);
    endtask
    task automatic t_fer;
        u_scu_card_model.send(8'h33, 1'b1, 31);
        rchk("status", 4'hE, 8'h03);
        tick(22);
        rchk("status", 4'hE, 8'h01);
        wr(4'h3, 8'h44);
        tick(2);
        chk("irq", {7'h00, IRQ_OUT_N}, 8'h01);
        wr(4'h3, 8'h04);
        rchk("hold", 4'hD, 8'h33);
        rchk("events", 4'h8, 8'h07);
        wr(4'h9, 8'h02);
        tick(2);
        chk("irq", {7'h00, IRQ_OUT_N}, 8'h00);
        wr(4'h8, 8'h02);
        tick(2);
        chk("irq", {7'h00, IRQ_OUT_N}, 8'h01);
        rchk("events", 4'h8, 8'h05);
    endtask
    task automatic t_tx;
        logic [9:0] f;
        f = {^8'hA5, 8'hA5, 1'b0};
        wr(4'h3, 8'h07);
        wr(4'h6, 8'h08);
        tick(2);
        rchk("status", 4'hE, 8'h01);
        wr(4'hD, 8'hA5);
        for (int i = 0; i < 40 && IO_OE !== 1'b1; i++) @(posedge CLOCK);
        // sample late in each bit so a wrong unit drifts into the next bit
        tick(11);
        for (int i = 0; i < 10; i++) begin
            chk("io_bit", {7'h00, IO_IN}, {7'h00, f[i]});
            tick(16);
        end
        wr(4'h6, 8'h00);
        tick(4);
        rchk("status", 4'hE, 8'h00);
    endtask
    task automatic t_wake;
        POWER_DOWN <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            wr(4'h3, k == 0 ? 8'h84 : k == 1 ? 8'h14 : 8'h04);
            tick(4);
            if (k == 1) HOST_RX <= 1'b0;
            else EXT_IRQ_PIN_N <= 1'b0;
            s = 1'b0;
            repeat (8) begin
                @(posedge CLOCK);
                s = s | WAKE;
            end
            chk("wake", {7'h00, s}, {7'h00, k < 2});
            HOST_RX       <= 1'b1;
            EXT_IRQ_PIN_N <= 1'b1;
            tick(4);
        end
        POWER_DOWN <= 1'b0;
    endtask
    task automatic t_sync;
        wr(4'h3, 8'h0C);
        wr(4'h1, 8'h01);
        tick(3);
        chk("sync_clk", {7'h00, SYNC_CLK}, 8'h01);
        wr(4'h1, 8'h00);
        tick(3);
        chk("sync_clk", {7'h00, SYNC_CLK}, 8'h00);
    endtask
    task automatic complete_run;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        tick(3);
        RST <= 1'b0;
        tick(1);
        t_regs;
        t_rx;
        t_fer;
        t_tx;
        t_wake;
        t_sync;
        complete_run;
    end
    initial begin
        tick(20000);
        failures++;
        complete_run;
    end
endmodule // scu_uart_bench
`default_nettype wire
